/* include/baud_pkg.sv */
package baud_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [4:0] baud_control_addr            = 5'h00;
  localparam logic [4:0] receive_status_control_addr  = 5'h04;
  localparam logic [4:0] baud_divisor_low_addr        = 5'h08;
  localparam logic [4:0] baud_divisor_high_addr       = 5'h0C;
  localparam logic [4:0] transmit_status_control_addr = 5'h10;

  // Field positions in baud_control.
  localparam int unsigned receive_idle_bit        = 6;
  localparam int unsigned wide_divisor_select_bit = 3;
  // Field positions in transmit_status_control.
  localparam int unsigned clock_source_select_bit = 7;
  localparam int unsigned sync_mode_bit           = 4;
  localparam int unsigned high_speed_select_bit   = 2;
  localparam int unsigned shift_empty_bit         = 1;

  // Writable masks and reset values.
  localparam logic [7:0] baud_control_wmask = 8'h1B;
  localparam logic [7:0] tx_status_wmask    = 8'hFD;
  localparam logic [7:0] rx_status_wmask    = 8'hF8;
  localparam logic [7:0] byte_zero          = 8'h00;

  // Prescale terminal counts: divide by 64, 16 or 4 clocks per divider step.
  localparam logic [5:0] prescale_64 = 6'h3F;
  localparam logic [5:0] prescale_16 = 6'h0F;
  localparam logic [5:0] prescale_4  = 6'h03;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Rate selection carried from the register file to the divider.
  typedef struct packed {
    logic        sync_mode;
    logic        wide_divisor;
    logic        high_speed;
    logic [15:0] divisor;
    logic        restart;
  } rate_cfg_s;

endpackage

/* design/baud_divider.sv */
`timescale 1ns/1ns
module baud_divider
(
  input  wire logic                aclk,      // System clock.
  input  wire logic                aresetn,   // Synchronous reset, active low.
  input  wire baud_pkg::rate_cfg_s cfg,       // Rate selection and restart.
  output logic                     rate_tick  // One-cycle bit-rate tick.
);

  typedef struct packed {
    logic [5:0]  pre;
    logic [15:0] count;
    logic        tick;
  } div_state_s;

  div_state_s q, d;
  logic [5:0]  pre_limit;
  logic [15:0] count_limit;

  // Prescale and divider width from the mode bits.
  always_comb
  begin
    if (cfg.sync_mode || (cfg.wide_divisor && cfg.high_speed))
      pre_limit = baud_pkg::prescale_4;  // RQ10 RQ12 RQ6
    else if (cfg.wide_divisor || cfg.high_speed)
      pre_limit = baud_pkg::prescale_16; // RQ9 RQ12 RQ5
    else
      pre_limit = baud_pkg::prescale_64; // RQ8
    if (cfg.wide_divisor)
      count_limit = cfg.divisor;         // RQ4 RQ2
    else
      count_limit = {8'h00, cfg.divisor[7:0]};
  end

  // Free-running divider: pre counts clocks, count counts up to n.
  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (cfg.restart)
    begin
      d.pre   = '0; // RQ7
      d.count = '0;
    end
    else if (q.pre >= pre_limit)
    begin
      d.pre = '0;
      if (q.count >= count_limit)
      begin
        d.count = '0; // RQ3
        d.tick  = 1'b1;
      end
      else
        d.count = q.count + 16'h0001;
    end
    else
      d.pre = q.pre + 6'h01;
  end

  // Reset clears the prescaler and the count, so the first period is a full one.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign rate_tick = q.tick;

endmodule

/* design/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync
(
  input  wire logic aclk,    // System clock.
  input  wire logic aresetn, // Synchronous reset, active low.
  input  wire logic pin_in,  // Asynchronous pin level.
  output logic      level    // Filtered level.
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_s;

  sync_state_s q, d;

  // Three stages; the level moves once stages two and three agree.
  always_comb
  begin
    d     = q;
    d.s1  = pin_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    if (q.s2 == q.s3)
      d.lvl = q.s3;
  end

  // Reset to the idle-high line level so that no false start bit follows reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '1;
    else
      q <= d;
  end

  assign level = q.lvl;

endmodule

/* design/baud_rate_generator.sv */
`timescale 1ns/1ns
// Behaviour
// RQ1 - One divider timer, 8-bit or 16-bit, times both asynchronous and synchronous operation.
// RQ2 - After reset the divider is 8-bit; setting wide_divisor_select makes it 16-bit.
// RQ3 - The divider runs continuously with a period set by the divisor byte pair.
// RQ4 - The divisor n is the high byte in bits 15:8 joined with the low byte in bits 7:0.
// RQ5 - In asynchronous mode high_speed_select and wide_divisor_select pick the multiplier.
// RQ6 - In synchronous mode high_speed_select does not change the rate.
// RQ7 - Writing either divisor byte clears the running count at once.
// RQ8 - Asynchronous, 8-bit, low speed divides the clock by 64 times (n+1).
// RQ9 - Asynchronous, 16-bit, low speed divides the clock by 16 times (n+1).
// RQ10 - Synchronous 8-bit divides the clock by 4 times (n+1) whatever high_speed_select holds.
// RQ11 - Software should see the receiver idle before changing the system clock.
// RQ12 - Async 8-bit high speed divides by 16(n+1); async 16-bit high speed and sync 16-bit by 4(n+1).
// RQ13 - The receive idle flag reads 1 while the receiver is idle and 0 while it receives.
// RQ14 - With synchronous mode and clock_source_select set, the serial clock comes from the divider.
module baud_rate_generator
(
  input  wire logic        aclk,            // System clock, 125 MHz.
  input  wire logic        aresetn,         // Synchronous reset, active low.
  input  wire logic [4:0]  s_axi_awaddr,    // Write address.
  input  wire logic        s_axi_awvalid,   // Write address valid.
  output logic             s_axi_awready,   // Write address ready.
  input  wire logic [31:0] s_axi_wdata,     // Write data.
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
  input  wire logic        s_axi_wvalid,    // Write data valid.
  output logic             s_axi_wready,    // Write data ready.
  output logic [1:0]       s_axi_bresp,     // Write response.
  output logic             s_axi_bvalid,    // Write response valid.
  input  wire logic        s_axi_bready,    // Write response ready.
  input  wire logic [4:0]  s_axi_araddr,    // Read address.
  input  wire logic        s_axi_arvalid,   // Read address valid.
  output logic             s_axi_arready,   // Read address ready.
  output logic [31:0]      s_axi_rdata,     // Read data.
  output logic [1:0]       s_axi_rresp,     // Read response.
  output logic             s_axi_rvalid,    // Read data valid.
  input  wire logic        s_axi_rready,    // Read data ready.
  input  wire logic        rx_pin,          // Asynchronous receive pin.
  input  wire logic        rx_busy,         // Receiver is assembling a character.
  input  wire logic        tx_shift_empty,  // Transmit shift register empty.
  output logic             rate_tick,       // One-cycle bit-rate tick.
  output logic             serial_clock_o,  // Synchronous master clock out.
  output logic             serial_clock_oe  // Clock pin drive enable.
);

  typedef struct packed {
    // Write channel holding state.
    logic        aw_held;
    logic [4:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_byte;
    logic        w_lane;
    logic        bvalid;
    logic [1:0]  bresp;
    // Read answer, captured at acceptance.
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    // Software-visible registers.
    logic [7:0]  baud_control;
    logic [7:0]  rx_status;
    logic [7:0]  div_low;
    logic [7:0]  div_high;
    logic [7:0]  tx_status;
    // Divider restart and output stages.
    logic        restart;
    logic        rx_idle;
    logic        tick;
    logic        sclk;
    logic        sclk_oe;
    // Registered ready flags, so the handshake outputs come from flip-flops.
    logic        awready;
    logic        wready;
    logic        arready;
  } regs_state_s;

  // Register state and the wiring between the bus, the divider and the filter.
  regs_state_s        q, d;
  baud_pkg::rate_cfg_s cfg;
  logic               div_tick;
  logic               rx_level;
  logic               do_write;
  logic [7:0]         rd_byte;
  logic               rd_ok;
  logic               master_clk;

  // Settings handed to the divider.
  // The speed bit is passed on as stored; the divider ignores it in synchronous mode.
  always_comb
  begin
    cfg.sync_mode    = q.tx_status[baud_pkg::sync_mode_bit];
    cfg.wide_divisor = q.baud_control[baud_pkg::wide_divisor_select_bit]; // RQ2
    cfg.high_speed   = q.tx_status[baud_pkg::high_speed_select_bit];      // RQ5
    cfg.divisor      = {q.div_high, q.div_low};                           // RQ4
    cfg.restart      = q.restart;                                         // RQ7
  end

  // The one divider times both asynchronous and synchronous operation.
  baud_divider u_divider
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cfg       (cfg),
    .rate_tick (div_tick)
  );

  // The receive line comes from a pin and is filtered before use.
  pin_sync u_rx_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (rx_pin),
    .level   (rx_level)
  );

  // Both halves of a write are held before the store; a pending response blocks the next.
  assign do_write   = q.aw_held && q.w_held && !q.bvalid;
  // The master clock is generated only in synchronous master mode.
  assign master_clk = q.tx_status[baud_pkg::sync_mode_bit]
                      && q.tx_status[baud_pkg::clock_source_select_bit];

  // Read mux; live status bits are merged into the returned byte.
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_byte = baud_pkg::byte_zero;
    case (s_axi_araddr)
      baud_pkg::baud_control_addr:
      begin
        // The receive idle flag is live; the stored bit under it is never read.
        rd_byte = {q.baud_control[7], q.rx_idle, q.baud_control[5:0]}; // RQ13
      end
      baud_pkg::receive_status_control_addr:
      begin
        rd_byte = q.rx_status;
      end
      baud_pkg::baud_divisor_low_addr:
      begin
        rd_byte = q.div_low; // RQ4
      end
      baud_pkg::baud_divisor_high_addr:
      begin
        rd_byte = q.div_high; // RQ4
      end
      baud_pkg::transmit_status_control_addr:
      begin
        // The shift-empty bit shows the partner's state, not a stored value.
        rd_byte = {q.tx_status[7:2], tx_shift_empty, q.tx_status[0]};
      end
      default:
      begin
        // Unmapped words answer with an error and read as zero.
        rd_ok = 1'b0;
      end
    endcase
  end

  // Bus slave, register writes and output stages.
  always_comb
  begin
    d         = q;
    d.restart = 1'b0;
    // Capture the write address on its own; it may come before or after the data.
    if (s_axi_awvalid && !q.aw_held)
    begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    // Capture the write data on its own; only byte lane zero carries a register.
    if (s_axi_wvalid && !q.w_held)
    begin
      d.w_held = 1'b1;
      d.w_byte = s_axi_wdata[7:0];
      d.w_lane = s_axi_wstrb[0];
    end
    // Store once both halves are held, then answer on the response channel.
    if (do_write)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = baud_pkg::resp_okay;
      case (q.aw_addr)
        baud_pkg::baud_control_addr:
        begin
          // Only the implemented control bits take the written value.
          if (q.w_lane)
            d.baud_control = q.w_byte & baud_pkg::baud_control_wmask; // RQ2
        end
        baud_pkg::receive_status_control_addr:
        begin
          // The error and ninth-bit flags below bit three stay zero.
          if (q.w_lane)
            d.rx_status = q.w_byte & baud_pkg::rx_status_wmask;
        end
        baud_pkg::baud_divisor_low_addr:
        begin
          if (q.w_lane)
            d.div_low = q.w_byte;
          // The count restarts even with the lane masked, so a rate change is prompt.
          d.restart = 1'b1; // RQ7
        end
        baud_pkg::baud_divisor_high_addr:
        begin
          if (q.w_lane)
            d.div_high = q.w_byte;
          d.restart = 1'b1; // RQ7
        end
        baud_pkg::transmit_status_control_addr:
        begin
          // The shift-empty bit is live status and is never stored.
          if (q.w_lane)
            d.tx_status = q.w_byte & baud_pkg::tx_status_wmask;
        end
        default:
        begin
          // An unmapped word changes nothing and reports an error.
          d.bresp = baud_pkg::resp_slverr;
        end
      endcase
    end
    else if (q.bvalid && s_axi_bready)
    begin
      // The response stands until the master takes it.
      d.bvalid = 1'b0;
    end
    // One read at a time, answered the cycle after acceptance.
    if (s_axi_arvalid && !q.rvalid)
    begin
      // Data are captured here, so later changes do not disturb a pending answer.
      d.rvalid = 1'b1;
      d.rdata  = rd_byte;
      if (rd_ok)
      begin
        d.rresp = baud_pkg::resp_okay;
      end
      else
      begin
        d.rresp = baud_pkg::resp_slverr;
      end
    end
    else if (q.rvalid && s_axi_rready)
    begin
      // The read answer stands until the master takes it.
      d.rvalid = 1'b0;
    end
    // Ready flags are registered copies of the next holding state.
    d.awready = !d.aw_held;
    d.wready  = !d.w_held;
    d.arready = !d.rvalid;
    // Idle unless the receiver is busy or the line sits in a start bit.
    d.rx_idle = !(rx_busy || !rx_level); // RQ13
    // The tick is registered once more so the output comes from a flip-flop.
    d.tick    = div_tick; // RQ1
    // Master clock toggles each tick; driven only in synchronous master mode.
    d.sclk_oe = master_clk; // RQ14
    if (!master_clk)
    begin
      // Outside master mode the clock rests high, ready for its first edge.
      d.sclk = 1'b1;
    end
    else if (div_tick)
    begin
      d.sclk = !q.sclk; // RQ14
    end
  end

  // All state moves on every edge; reset leaves the bus ready and the receiver idle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.rx_idle <= 1'b1;
      q.sclk    <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Bus handshake outputs.
  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rresp     = q.rresp;
  // Registers are one byte wide; the upper read lanes are always zero.
  assign s_axi_rdata     = {24'h00_0000, q.rdata};
  // Serial side outputs.
  assign rate_tick       = q.tick;
  assign serial_clock_o  = q.sclk;
  assign serial_clock_oe = q.sclk_oe;

endmodule

/* tb/baud_rate_generator_monitor.sv */
`timescale 1ns/1ns
module baud_rate_generator_monitor
(
  input logic        aclk,            // Clock.
  input logic        aresetn,         // Reset, low.
  input logic        s_axi_awvalid,   // Aw valid.
  input logic        s_axi_awready,   // Aw ready.
  input logic        s_axi_wvalid,    // W valid.
  input logic        s_axi_wready,    // W ready.
  input logic        s_axi_bvalid,    // B valid.
  input logic        s_axi_bready,    // B ready.
  input logic        s_axi_arvalid,   // Ar valid.
  input logic        s_axi_arready,   // Ar ready.
  input logic [31:0] s_axi_rdata,     // Read data.
  input logic        s_axi_rvalid,    // R valid.
  input logic        s_axi_rready,    // R ready.
  input logic        rate_tick,       // Tick.
  input logic        serial_clock_o,  // Serial clock.
  input logic        serial_clock_oe  // Clock enable.
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped early.");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read answer changed early.");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("Read taken while busy.");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("Write response late.");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read answer late.");
  property p_rdata_top;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_top: assert property (p_rdata_top) else $error("Read data upper bits set.");
  property p_tick_gap;
    rate_tick |=> !rate_tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Ticks too close.");
  property p_clock_idle;
    !serial_clock_oe && !$past(serial_clock_oe) |-> serial_clock_o;
  endproperty
  a_clock_idle: assert property (p_clock_idle) else $error("Idle clock not high.");
  property p_clock_toggle;
    serial_clock_oe |-> ((serial_clock_o != $past(serial_clock_o)) == rate_tick);
  endproperty
  a_clock_toggle: assert property (p_clock_toggle) else $error("Clock edge off tick.");
  c_tick: cover property (rate_tick);
  c_master: cover property ($rose(serial_clock_oe));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind baud_rate_generator baud_rate_generator_monitor mon
  (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .rate_tick, .serial_clock_o, .serial_clock_oe);

/* tb/serial_shift_model.sv */
`timescale 1ns/1ns
module serial_shift_model
(
  input  logic aclk,           // System clock.
  input  logic aresetn,        // Reset, active low.
  input  logic rate_tick,      // Bit-rate tick.
  input  logic go,             // Starts a frame.
  output logic rx_pin,         // Receive line.
  output logic rx_busy,        // Receiving.
  output logic tx_shift_empty  // Shift register empty.
);
  logic [3:0] bits_q;
  // Counts ten bit times of a frame, one per tick.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bits_q <= 4'h0;
    else if (go)
      bits_q <= 4'hA;
    else if (rate_tick && bits_q != 4'h0)
      bits_q <= bits_q - 4'h1;
  end
  // Start bit low, then alternating data; the line idles high.
  assign rx_pin = (bits_q == 4'h0) || (bits_q != 4'hA && bits_q[0]);
  assign rx_busy = bits_q != 4'h0;
  assign tx_shift_empty = bits_q == 4'h0;
endmodule

/* tb/baud_rate_generator_tb.sv */
`timescale 1ns/1ns
module baud_rate_generator_tb;
  localparam logic [4:0] a_bc = baud_pkg::baud_control_addr;
  localparam logic [4:0] a_lo = baud_pkg::baud_divisor_low_addr;
  localparam logic [4:0] a_hi = baud_pkg::baud_divisor_high_addr;
  localparam logic [4:0] a_tx = baud_pkg::transmit_status_control_addr;
  logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        aw_r, w_r, b_v, ar_r, r_v, rx_pin, rx_busy, tx_empty, tick, sck, sck_oe;
  logic [4:0]  aw_addr = 5'h00, ar_addr = 5'h00;
  logic [31:0] w_data = 32'h0000_0000, r_data, d;
  logic [1:0]  b_resp, r_resp, rs;
  logic [15:0] p;
  int          failures = 0, checks = 0;
  // Rows: transmit control, baud control, divisor high, low, expected period.
  logic [47:0] rows [8] = '{48'h0000_0002_00C0, 48'h0400_0001_0020, 48'h0008_0102_1030,
    48'h0408_0005_0018, 48'h9000_0003_0010, 48'h1400_0003_0010, 48'h1008_0100_0404,
    48'h0000_0100_0040};
  baud_rate_generator uut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_data),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .rx_pin(rx_pin),
    .rx_busy(rx_busy), .tx_shift_empty(tx_empty), .rate_tick(tick), .serial_clock_o(sck),
    .serial_clock_oe(sck_oe)
  );
  serial_shift_model far
  (
    .aclk(aclk), .aresetn(aresetn), .rate_tick(tick), .go(go), .rx_pin(rx_pin),
    .rx_busy(rx_busy), .tx_shift_empty(tx_empty)
  );
  // The 125 MHz system clock.
  initial forever #4 aclk = ~aclk;
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One write; address and data are released as each is taken.
  task automatic wr(input logic [4:0] a, input logic [7:0] v,
                    input logic [1:0] e = baud_pkg::resp_okay);
    @(posedge aclk);
    aw_addr <= a;
    w_data <= {24'h00_0000, v};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw_r === 1'b1) aw_v <= 1'b0;
      if (w_r === 1'b1) w_v <= 1'b0;
    end
    while (b_v !== 1'b1);
    b_r <= 1'b0;
    chk(32'(b_resp), 32'(e));
  endtask
  // One read; data and response land in d and rs.
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    ar_addr <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ar_r === 1'b1) ar_v <= 1'b0;
    end
    while (r_v !== 1'b1);
    r_r <= 1'b0;
    d = r_data;
    rs = r_resp;
  endtask
  // Counts clocks up to the next tick.
  task automatic gap;
    p = 16'h0000;
    do
    begin
      @(posedge aclk);
      p++;
    end
    while (tick !== 1'b1);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge aclk);
    failures++;
    final_report;
  end
  // Rate table, then reset values, refusals, restart and a frame.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(a_tx, rows[i][47:40]);
      wr(a_bc, rows[i][39:32]);
      wr(a_hi, rows[i][31:24]);
      wr(a_lo, rows[i][23:16]);
      repeat (3) gap;
      chk(32'(p), 32'(rows[i][15:0]));
      chk(32'(sck_oe), 32'(rows[i][47] & rows[i][44]));
    end
    $display("rate table done");
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(5'(4 * i));
      chk(d, 32'(40'h40_0000_0002 >> (32 - 8 * i)) & 32'h0000_00FF);
    end
    wr(5'h14, 8'hFF, baud_pkg::resp_slverr);
    rd(5'h14);
    chk(32'(rs), 32'(baud_pkg::resp_slverr));
    wr(a_bc, 8'hFF);
    rd(a_bc);
    chk(d, 32'h0000_005B);
    $display("reset and refusal done");
    wr(a_bc, 8'h00);
    wr(a_lo, 8'h14);
    repeat (2) gap;
    repeat (600) @(posedge aclk);
    wr(a_lo, 8'h14);
    gap;
    chk(32'(p > 16'h0538 && p < 16'h0546), 32'h0000_0001);
    repeat (600) @(posedge aclk);
    wr(a_hi, 8'h00);
    gap;
    chk(32'(p > 16'h0538 && p < 16'h0546), 32'h0000_0001);
    $display("restart done");
    wr(a_lo, 8'h00);
    wr(a_tx, 8'h90);
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    rd(a_bc);
    chk(32'(d[6]), 32'h0000_0000);
    rd(a_tx);
    chk(32'(d[1]), 32'h0000_0000);
    do rd(a_bc); while (d[6] !== 1'b1);
    rd(a_tx);
    chk(32'(d[1]), 32'h0000_0001);
    $display("frame done");
    final_report;
  end
endmodule
